/* File: rtl/event_fifo_serial_link.sv */
// event word formatter, frame tag and integration gating, fifo and serial link sender
// assumes the mode, strobe, row, run, tag enable and bit zero pins are asynchronous and pass two flip-flops; event data inputs are used unsynchronised
`timescale 1ns/1ps
// Operation
// RULE_01: low res windowed word field order
// RULE_02: height mode word with tag 0001
// RULE_03: energy mode word with tag 0010
// RULE_04: ignore first-mode words during pair write
// RULE_05: pair second word uses delayed y lookup
// RULE_06: host clears low mode bit before pairs
// RULE_07: first row edge pulse clears fifo
// RULE_08: tag pulse delayed two cycles writes zeros
// RULE_09: mode latch bit enables frame tag
// RULE_10: tag writes only while integrating
// RULE_11: strobe latches bit zero, cleared at reset
// RULE_12: request sampled at image run rise
// RULE_13: host sets mode before integration request
// RULE_14: reads on same clock as writes
// RULE_15: start sending when data and idle
// RULE_16: busy fall makes read, loads shifter
// RULE_17: select shift data, then raise frame
// RULE_18: msb first on first rising edge
// RULE_19: final bit is odd parity, frame drops
// RULE_20: four bit counter marks bit seven, end
// RULE_21: 24 clocks per word, two gap
// RULE_22: link clock divided, at most 5 MHz
// RULE_23: two independent link output sets
// RULE_24: data low and frame low when idle
// RULE_25: full store discards new words
// RULE_26: tag enable is active low
module event_fifo_serial_link
    import event_link_pkg::*;
#(
    parameter int FIFO_W  = SHIFT_W - 1,
    parameter int FIFO_D  = FIFO_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  acq_mode,
    input  wire logic        mode_low_bit_request,
    input  wire logic        frame_tag_enable_n,
    input  wire logic        event_strobe,
    input  wire logic        double_flag,
    input  wire logic [7:0]  x_pos,
    input  wire logic [7:0]  y_pos,
    input  wire logic [2:0]  x_sub,
    input  wire logic [2:0]  y_sub,
    input  wire logic [3:0]  window_id,
    input  wire logic [7:0]  event_height,
    input  wire logic [7:0]  event_energy,
    input  wire logic [15:0] lookup_x,
    input  wire logic [15:0] lookup_y_delayed,
    input  wire logic        first_data_row,
    input  wire logic        integration_strobe_n,
    input  wire logic        bus_data_bit0,
    input  wire logic        image_clock_run_n,
    output logic             integration_active,
    output logic             fifo_clear_n,
    output logic             fifo_has_room,
    output logic             link_clock_buffered,
    output logic             serial_line_out,
    output logic             frame_sync,
    output logic             link_clock_b,
    output logic             serial_line_out_b,
    output logic             frame_sync_b
);
    // two flop synchronisers for every asynchronous pin
    localparam int NSYNC = 3 + 7;
    localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h025; // strobe, run, tag enable idle high
    logic [NSYNC-1:0] meta_r;                     // first stage
    logic [NSYNC-1:0] sync_r;                     // second stage, only this is read
    wire  [NSYNC-1:0] pins = {acq_mode, mode_low_bit_request, frame_tag_enable_n,
                              first_data_row, event_strobe, integration_strobe_n,
                              bus_data_bit0, image_clock_run_n};
    wire  [2:0] mode_s   = sync_r[9:7];          // synchronised mode
    wire        low_req  = sync_r[6];            // low mode bit request
    wire        tag_en_n = sync_r[5];            // synchronised tag enable
    wire        first_s  = sync_r[4];            // first data row
    wire        evt_s    = sync_r[3];            // event strobe
    wire        istb_n_s = sync_r[2];            // integration strobe
    wire        bd0_s    = sync_r[1];            // data bit zero
    wire        image_clock_run_n_n_s = sync_r[0];            // image run

    // pin synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= SYNC_IDLE;                  // idle levels, so no false edge
            sync_r <= SYNC_IDLE;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
        end
    end

    // edge history for the synchronised strobes
    logic first_d_r;                              // first row delayed
    logic istb_d_r;                               // integration strobe delayed
    logic image_clock_run_n_d_r;                               // image run delayed
    logic evt_d_r;                                // event strobe delayed
    wire  first_rise = first_s && !first_d_r;
    wire  istb_fall  = !istb_n_s && istb_d_r;
    wire  image_clock_run_n_rise  = image_clock_run_n_n_s && !image_clock_run_n_d_r;
    wire  evt_rise   = evt_s && !evt_d_r;

    // edge history
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            first_d_r <= 1'b0;
            istb_d_r  <= 1'b1;
            image_clock_run_n_d_r  <= 1'b1;
            evt_d_r   <= 1'b0;
        end else begin
            first_d_r <= first_s;
            istb_d_r  <= istb_n_s;
            image_clock_run_n_d_r  <= image_clock_run_n_n_s;
            evt_d_r   <= evt_s;
        end
    end

    // integration request and active enable
    logic integration_request;                    // request latch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            integration_request <= 1'b0;          // RULE_11
            integration_active  <= 1'b0;
        end else begin
            if (istb_fall) integration_request <= bd0_s; // RULE_11
            if (image_clock_run_n_rise) integration_active <= integration_request; // RULE_12
        end
    end

    // fifo clear pulse on first row edge, combined with local reset
    wire clear_pulse = first_rise || !rst_n;      // RULE_07
    assign fifo_clear_n = !clear_pulse;           // RULE_07

    // frame tag request: delayed two cycles, gated by enable and integration
    logic [TAG_DELAY-1:0] tag_dly_r;              // tag delay chain
    wire  tag_gate = first_rise && !tag_en_n && integration_active; // RULE_09 RULE_10 RULE_26
    wire  tag_write = tag_dly_r[TAG_DELAY-1];     // RULE_08
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tag_dly_r <= '0;
        end else begin
            tag_dly_r <= {tag_dly_r[TAG_DELAY-2:0], tag_gate}; // RULE_08
        end
    end

    // pair logic: second word of an engineering pair two cycles later
    logic [PAIR_DELAY-1:0] pair_r;                // pending second word
    logic                  pair_sel_r;            // low mode bit latched outside pair modes
    wire  eng_pair = mode_s[2];
    wire  pair_busy = |pair_r;
    wire  second_now = pair_r[PAIR_DELAY-1];
    wire  first_ok = evt_rise && !pair_busy;      // RULE_04
    wire  mode_lo = eng_pair ? (second_now ? !pair_sel_r : pair_sel_r) : low_req;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pair_r     <= '0;
            pair_sel_r <= 1'b0;
        end else begin
            pair_r <= {pair_r[PAIR_DELAY-2:0], first_ok && eng_pair}; // RULE_04
            if (!eng_pair) pair_sel_r <= low_req; // RULE_06
        end
    end

    // word formatting by mode
    wire [2:0] eff_mode = {mode_s[2:1], mode_lo};
    wire [15:0] mn_val  = second_now ? lookup_y_delayed : lookup_x; // RULE_05
    logic [WORD_W-1:0] fmt_word;
    always_comb begin
        case (acq_mode_t'(eff_mode))
            MODE_LOW_WIN, MODE_LOW_FULL:
                fmt_word = {double_flag, y_pos[6:0], y_sub[2:1],
                            x_pos[6:0], x_sub[2:1], window_id}; // RULE_01
            MODE_HI_WIN, MODE_HI_FULL:
                fmt_word = {double_flag, y_pos[5:0], y_sub,
                            x_pos[5:0], x_sub, window_id};
            MODE_XMN, MODE_YMN:
                fmt_word = {double_flag, 1'b0, mn_val[15:8], 1'b0, mn_val[7:0],
                            2'b00, mode_lo, 1'b1};
            MODE_HEIGHT:
                fmt_word = {double_flag, 10'h000, event_height, TAG_HEIGHT}; // RULE_02
            MODE_ENERGY:
                fmt_word = {double_flag, 10'h000, event_energy, TAG_ENERGY}; // RULE_03
            default:
                fmt_word = ZERO_WORD;
        endcase
    end

    // write gating: tag wins, else first event or pair second word
    wire data_write = (first_ok || second_now) && integration_active;
    wire fifo_in_valid = (tag_write || data_write) && !clear_pulse;
    wire [WORD_W-1:0] fifo_in_data = tag_write ? ZERO_WORD : fmt_word; // RULE_08
    logic fifo_in_ready;
    assign fifo_has_room = fifo_in_ready;         // RULE_25

    // shared clock fifo; a refused word is simply dropped
    logic [WORD_W-1:0] fifo_out_word;
    logic              fifo_out_valid;
    logic              read_pulse;
    word_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (clear_pulse),
        .in_data   (fifo_in_data),
        .in_valid  (fifo_in_valid),           // RULE_25
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_word),
        .out_valid (fifo_out_valid),
        .out_ready (read_pulse)               // RULE_14
    );

    // link clock divider from the system clock
    localparam int DW = $clog2(LINK_HALF_CYC + 1);
    logic [DW-1:0] div_r;                         // divider count
    logic          link_clock;                    // divided clock level
    wire           div_end = (div_r == DW'(LINK_HALF_CYC - 1));
    wire           link_rise = div_end && !link_clock; // next edge is rising
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_r      <= '0;
            link_clock <= 1'b0;
        end else begin
            div_r <= div_end ? '0 : div_r + 1'b1;
            if (div_end) link_clock <= !link_clock; // RULE_22
        end
    end

    // transmitter state, all stepped on link clock rising edges
    tx_state_t         st_r;                      // sequence state
    logic [SHIFT_W-1:0] shreg_r;                  // output shifter
    logic              parity_r;                  // running parity
    logic [3:0]        bit_cnt_r;                 // bit counter
    logic              count_seven_seen;          // seventh bit passed
    logic              output_bit_select;         // high selects parity
    logic [1:0]        gap_r;                     // gap clocks
    logic              synced_empty_busy;         // busy flag
    wire  count_seven = (bit_cnt_r == BITS_MARK);  // RULE_20
    wire  frame_end_n = !(count_seven && count_seven_seen); // RULE_20
    wire  shift_out = shreg_r[SHIFT_W-1];
    assign synced_empty_busy = (st_r != TX_IDLE);
    wire  read_cycle_pulse = link_rise && (st_r == TX_IDLE) && fifo_out_valid; // RULE_15
    assign read_pulse = read_cycle_pulse;         // RULE_16

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r              <= TX_IDLE;
            shreg_r           <= '0;
            parity_r          <= 1'b0;
            bit_cnt_r         <= CNT_RESET;
            count_seven_seen  <= 1'b0;
            output_bit_select <= 1'b1;
            frame_sync        <= 1'b0;
            serial_line_out   <= 1'b0;
            gap_r             <= '0;
        end else if (link_rise) begin
            case (st_r)
                TX_IDLE: begin
                    if (fifo_out_valid) begin
                        shreg_r <= {fifo_out_word, 1'b0}; // RULE_16
                        st_r    <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    output_bit_select <= 1'b0;    // RULE_17
                    parity_r  <= 1'b1;            // odd parity seed
                    bit_cnt_r <= CNT_RESET;
                    count_seven_seen <= 1'b0;
                    st_r <= TX_SEL;
                end
                TX_SEL: begin
                    frame_sync      <= 1'b1;      // RULE_17
                    serial_line_out <= shift_out; // RULE_18
                    parity_r <= parity_r ^ shift_out; // RULE_19
                    shreg_r  <= shreg_r << 1;
                    st_r     <= TX_SHIFT;
                end
                TX_SHIFT: begin
                    bit_cnt_r <= bit_cnt_r + 1'b1; // RULE_20
                    if (count_seven) count_seven_seen <= 1'b1; // RULE_20
                    if (!frame_end_n) begin
                        output_bit_select <= 1'b1; // RULE_20
                        serial_line_out   <= parity_r; // RULE_19
                        st_r <= TX_PAR;
                    end else begin
                        serial_line_out <= shift_out; // RULE_18
                        parity_r <= parity_r ^ shift_out;
                        shreg_r  <= shreg_r << 1;
                    end
                end
                TX_PAR: begin
                    frame_sync      <= 1'b0;      // RULE_19
                    serial_line_out <= 1'b0;      // RULE_24
                    gap_r <= '0;
                    st_r  <= TX_GAP;
                end
                TX_GAP: begin
                    gap_r <= gap_r + 1'b1;
                    if (gap_r == 2'h1) st_r <= TX_IDLE; // RULE_21
                end
                default: st_r <= TX_IDLE;
            endcase
        end
    end

    // two link output sets driven by the same registers
    assign link_clock_buffered = link_clock;      // RULE_23
    assign link_clock_b        = link_clock;      // RULE_23
    assign serial_line_out_b   = serial_line_out; // RULE_23
    assign frame_sync_b        = frame_sync;      // RULE_23
endmodule : event_fifo_serial_link

/* File: rtl/event_link_pkg.sv */
// package of word layouts, link timing and reset values for the event serial link
// assumes a single 100 MHz system clock shared by every file that imports it
package event_link_pkg;
    localparam int          WORD_W        = 23;            // formatted event word width
    localparam int          SHIFT_W       = 24;            // word plus parity
    localparam int          SYS_CLK_MHZ   = 100;           // system clock rate
    localparam int          LINK_MAX_MHZ  = 5;             // fastest allowed link clock
    localparam int          LINK_HALF_CYC = (SYS_CLK_MHZ + 2 * LINK_MAX_MHZ - 1)
                                            / (2 * LINK_MAX_MHZ); // half period in cycles
    localparam int          PAIR_DELAY    = 2;             // second pair word follows by 2 cycles
    localparam int          TAG_DELAY     = 2;             // tag preset delay in cycles
    localparam int          FIFO_DEPTH    = 4;             // buffer depth in words
    localparam int          FIFO_FULL_WORDS = 512;         // documented store size
    localparam logic [3:0]  TAG_HEIGHT    = 4'h1;          // height mode low tag
    localparam logic [3:0]  TAG_ENERGY    = 4'h2;          // energy mode low tag
    localparam logic [3:0]  BITS_MARK     = 4'h7;          // counter value marking 7th bit
    localparam logic [3:0]  CNT_RESET     = 4'h1;          // counter load value
    localparam logic [WORD_W-1:0] ZERO_WORD = 23'h000000;  // frame tag word

    // acquisition modes
    typedef enum logic [2:0] {
        MODE_LOW_WIN  = 3'h0,
        MODE_LOW_FULL = 3'h1,
        MODE_HI_WIN   = 3'h2,
        MODE_HI_FULL  = 3'h3,
        MODE_XMN      = 3'h4,
        MODE_YMN      = 3'h5,
        MODE_HEIGHT   = 3'h6,
        MODE_ENERGY   = 3'h7
    } acq_mode_t;

    // link transmitter states
    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_LOAD  = 3'h1,
        TX_SEL   = 3'h2,
        TX_SHIFT = 3'h3,
        TX_PAR   = 3'h4,
        TX_GAP   = 3'h5
    } tx_state_t;
endpackage : event_link_pkg

/* File: rtl/word_fifo.sv */
// small synchronous word fifo with valid and ready on both sides
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];     // storage
    logic [AW-1:0]    wr_r;              // write pointer
    logic [AW-1:0]    rd_r;              // read pointer
    logic [AW:0]      cnt_r;             // words held
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // pointer step with wrap
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : step

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];

    // storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clear) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) wr_r <= step(wr_r);
            if (pop)  rd_r <= step(rd_r);
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : word_fifo

/* File: test/event_link_checker.sv */
// assertions on link framing, link clock, fifo clear and integration gating
// assumes it is bound to the sender top and sees only its ports
`timescale 1ns/1ps
module event_link_checker (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic first_data_row,
    input wire logic image_clock_run_n,
    input wire logic integration_active,
    input wire logic fifo_clear_n,
    input wire logic link_clock_buffered,
    input wire logic serial_line_out,
    input wire logic frame_sync,
    input wire logic link_clock_b,
    input wire logic serial_line_out_b,
    input wire logic frame_sync_b
);
    logic [9:0] hi_cnt_r;  // cycles with frame high
    logic [9:0] gap_cnt_r; // cycles with frame low, saturating
    logic [4:0] bit_cnt_r; // bits taken mid-period
    logic       ones_r;    // running parity of those bits
    logic [3:0] run_age_r; // cycles since image run rose, saturating
    logic       lck_r;     // link clock one cycle ago
    logic       run_r;     // image run one cycle ago
    wire logic  mid_bit = lck_r && !link_clock_buffered; // link clock fell
    wire logic  run_up  = !run_r && image_clock_run_n;   // image run rose
    // per-frame counters
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {hi_cnt_r, bit_cnt_r, ones_r, lck_r} <= '0;
            gap_cnt_r <= 10'h3FF;
            run_age_r <= 4'hF;
            run_r     <= 1'b1;
        end else begin
            lck_r     <= link_clock_buffered;
            run_r     <= image_clock_run_n;
            hi_cnt_r  <= frame_sync ? hi_cnt_r + 10'h1 : 10'h0;
            gap_cnt_r <= frame_sync ? 10'h0 : gap_cnt_r + 10'(gap_cnt_r != 10'h3FF);
            bit_cnt_r <= frame_sync ? bit_cnt_r + 5'(mid_bit) : 5'h0;
            ones_r    <= frame_sync && (ones_r ^ (mid_bit && serial_line_out));
            run_age_r <= run_up ? 4'h0 : run_age_r + 4'(run_age_r != 4'hF);
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_idle_data_low: assert property (!frame_sync && !$past(frame_sync) |-> !serial_line_out)
        else $error("idle data high");
    a_link_sets_match: assert property (
        serial_line_out_b == serial_line_out && frame_sync_b == frame_sync
        && link_clock_b == link_clock_buffered) else $error("link sets differ");
    a_link_clk_high: assert property (
        $rose(link_clock_buffered) |=> link_clock_buffered[*8] ##1 link_clock_buffered
        ##1 !link_clock_buffered) else $error("link clock high");
    a_frame_length: assert property (
        $fell(frame_sync) |-> hi_cnt_r >= 10'd478 && hi_cnt_r <= 10'd482)
        else $error("frame length");
    a_bit_count: assert property ($fell(frame_sync) |-> bit_cnt_r == 5'd24)
        else $error("bit count");
    a_parity_odd: assert property ($fell(frame_sync) |-> ones_r)
        else $error("parity even");
    a_frame_gap: assert property ($rose(frame_sync) |-> gap_cnt_r >= 10'd39)
        else $error("gap short");
    a_row_clears: assert property ($rose(first_data_row) |-> ##[1:5] !fifo_clear_n)
        else $error("no fifo clear");
    a_clear_short: assert property ($fell(fifo_clear_n) |=> ##[0:2] fifo_clear_n)
        else $error("clear too long");
    a_run_gates: assert property ($changed(integration_active) |-> run_age_r <= 4'd6)
        else $error("integration off run edge");
    c_frame: cover property ($rose(frame_sync));
    c_integ: cover property ($rose(integration_active));
    c_clear: cover property ($rose(first_data_row) ##[1:5] !fifo_clear_n);
endmodule : event_link_checker

bind event_fifo_serial_link event_link_checker i_event_link_checker (
    .sys_clk, .rst_n, .first_data_row, .image_clock_run_n, .integration_active,
    .fifo_clear_n, .link_clock_buffered, .serial_line_out, .frame_sync, .link_clock_b,
    .serial_line_out_b, .frame_sync_b
);

/* File: test/link_receiver.sv */
// receiver model on the far side of the serial link, gathers each frame
// assumes link signals change on the link clock rise, so bits are taken mid-period
`timescale 1ns/1ps
module link_receiver (
    input  wire logic        sys_clk,
    input  wire logic        link_clock,
    input  wire logic        serial_in,
    input  wire logic        frame_in,
    output logic      [23:0] rx_word_r,
    output logic             rx_valid_r
);
    logic        lck_r; // link clock one cycle ago
    logic        frm_r; // frame one cycle ago
    logic [23:0] sh_r;  // bits gathered msb first
    // shift in on each link fall inside a frame, hand on at frame end
    always_ff @(posedge sys_clk) begin
        lck_r      <= link_clock;
        frm_r      <= frame_in;
        rx_valid_r <= 1'b0;
        if (lck_r && !link_clock && frame_in) begin
            sh_r <= {sh_r[22:0], serial_in};
        end
        if (frm_r && !frame_in) begin
            rx_word_r  <= sh_r;
            rx_valid_r <= 1'b1;
        end
    end
endmodule : link_receiver

/* File: test/testbench.sv */
// self-checking bench: refused events, fill and drain, pairs, frame tags
// assumes the receiver model gathers frames and the checker is bound
`timescale 1ns/1ps
module testbench
    import event_link_pkg::*;
;
    logic        sys_clk, rst_n, mode_low_bit_request, frame_tag_enable_n, event_strobe;
    logic        double_flag, first_data_row, integration_strobe_n, bus_data_bit0;
    logic        image_clock_run_n, integration_active, fifo_clear_n, fifo_has_room;
    logic        link_clock_buffered, serial_line_out, frame_sync, rx_valid_r;
    logic [2:0]  acq_mode, x_sub, y_sub;
    logic [3:0]  window_id;
    logic [7:0]  x_pos, y_pos, event_height, event_energy;
    logic [15:0] lookup_x, lookup_y_delayed;
    logic [23:0] rx_word_r;
    logic [23:0] exp_q[$]; // expected frames, oldest first
    int          errors, total_checks, cyc;
    event_fifo_serial_link i_event_fifo_serial_link (
        .sys_clk, .rst_n, .acq_mode, .mode_low_bit_request, .frame_tag_enable_n,
        .event_strobe, .double_flag, .x_pos, .y_pos, .x_sub, .y_sub, .window_id,
        .event_height, .event_energy, .lookup_x, .lookup_y_delayed, .first_data_row,
        .integration_strobe_n, .bus_data_bit0, .image_clock_run_n, .integration_active,
        .fifo_clear_n, .fifo_has_room, .link_clock_buffered, .serial_line_out, .frame_sync,
        .link_clock_b(), .serial_line_out_b(), .frame_sync_b()
    );
    link_receiver i_link_receiver (
        .sys_clk, .link_clock(link_clock_buffered), .serial_in(serial_line_out),
        .frame_in(frame_sync), .rx_word_r, .rx_valid_r
    );
    always #5 sys_clk = ~sys_clk;
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // note word plus odd parity
    task automatic push(input logic [22:0] w);
        exp_q.push_back({w, ~^w});
    endtask : push
    // latch request, apply on image run rise
    task automatic set_integ(input logic v, input logic was);
        bus_data_bit0 = v;
        integration_strobe_n = 1'b0;
        tick(4);
        integration_strobe_n = 1'b1;
        tick(6);
        check(24'(integration_active), 24'(was));
        image_clock_run_n = 1'b0;
        tick(4);
        image_clock_run_n = 1'b1;
        tick(8);
        check(24'(integration_active), 24'(v));
    endtask : set_integ
    // one random event; room judged just before the writing edge
    task automatic send();
        logic ok;
        {double_flag, x_pos, y_pos, x_sub, y_sub, window_id} = 27'($urandom);
        {event_height, event_energy, lookup_x} = 32'($urandom);
        lookup_y_delayed = 16'($urandom);
        event_strobe = 1'b1;
        tick(2);
        ok = fifo_has_room && integration_active;
        if (ok && acq_mode == MODE_LOW_WIN) begin
            push({double_flag, y_pos[6:0], y_sub[2:1], x_pos[6:0], x_sub[2:1], window_id});
        end
        if (ok && acq_mode == MODE_HEIGHT) begin
            push({double_flag, 10'h000, event_height, TAG_HEIGHT});
            push({double_flag, 10'h000, event_energy, TAG_ENERGY});
        end
        event_strobe = 1'b0;
        tick(2);
    endtask : send
    // row edge clears fifo; tag word if enabled
    task automatic row();
        if (integration_active === 1'b1 && frame_tag_enable_n === 1'b0) begin
            push(ZERO_WORD);
        end
        first_data_row = 1'b1;
        tick(6);
        first_data_row = 1'b0;
        tick(4);
    endtask : row
    // wait for noted frames, then catch strays
    task automatic drain(input string name);
        for (int i = 0; i < 6000 && exp_q.size() != 0; i++) tick(1);
        tick(700);
        check(24'(exp_q.size()), 24'h0);
        $display("test %s done", name);
    endtask : drain
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // match each frame to oldest note
    always @(posedge sys_clk) begin
        if (rx_valid_r === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("wrong value at %0t: frame not expected", $time);
            end else begin
                check(rx_word_r, exp_q.pop_front());
            end
        end
    end
    // cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            $display("wrong value at %0t: run did not finish", $time);
            close_out();
        end
    end
    initial begin
        {sys_clk, rst_n, mode_low_bit_request, event_strobe, first_data_row} = '0;
        {bus_data_bit0, double_flag, x_pos, y_pos, x_sub, y_sub, window_id} = '0;
        {event_height, event_energy, lookup_x, lookup_y_delayed} = '0;
        {integration_strobe_n, image_clock_run_n, frame_tag_enable_n} = '1;
        acq_mode = MODE_LOW_WIN;
        void'($urandom(79382));
        tick(20);
        rst_n = 1'b1;
        tick(4);
        check(24'(integration_active), 24'h0);
        check(24'(fifo_has_room), 24'h1);
        repeat (2) send();
        drain("idle");
        set_integ(1'b1, 1'b0);
        repeat (7) send();
        check(24'(fifo_has_room), 24'h0);
        drain("fill");
        acq_mode = MODE_HEIGHT;
        tick(4);
        send();
        drain("pair");
        acq_mode = MODE_LOW_WIN;
        frame_tag_enable_n = 1'b0;
        row();
        drain("tag");
        frame_tag_enable_n = 1'b1;
        row();
        send();
        drain("no tag");
        set_integ(1'b0, 1'b1);
        frame_tag_enable_n = 1'b0;
        row();
        send();
        drain("tag idle");
        close_out();
    end
endmodule : testbench
